// ===== verilog/adc_cmp_ctrl.sv
// converter timing control and analog comparator control with an AXI4-Lite slave
// assumes analog core and timer capture logic sit outside; all inputs synchronous
//
// Notes on behaviour
// - mux enable, converter off: mux feeds comparator
// - mux enable clear: negative pin feeds comparator
// - disable bit powers comparator down
// - bandgap select replaces positive pin input
// - output status is synchronised, 2 cycles late
// - matching output change sets event flag
// - event flag clears on vector or write-one
// - irq needs flag, enable and global enable
// - capture route feeds timer capture front end
// - prescaler divides by selected ratio
// - prescaler held reset while converter disabled
// - start begins at next converter clock rise
// - normal conversion lasts 13 converter cycles
// - first conversion lasts 25 converter cycles
// - free running restarts while start stays high
// - sample at 1.5, first at 13.5
// - auto 2 / 13.5, free 2.5 / 14
// - channel select locked during conversion except its last converter cycle
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
module adc_cmp_ctrl
(
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // register bus
  input wire adc_cmp_pkg::axi_req_t i_axi,
  output adc_cmp_pkg::axi_rsp_t o_axi,
  // comparator side
  input wire logic i_comp_raw,
  input wire logic i_comp_irq_ack,
  input wire logic i_global_irq_enable,
  output logic o_comp_neg_from_mux,
  output logic o_comp_pos_bandgap,
  output logic o_comp_power_down,
  output logic o_capture_input,
  output logic o_comp_irq,
  // converter side
  input wire logic i_trigger,
  input wire logic i_conv_irq_ack,
  output logic o_converter_clock,
  output logic o_sample_hold,
  output logic o_conversion_done,
  output logic o_first_conversion,
  output logic [7:0] o_channel_select,
  output logic o_conv_irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cmp_cs;
    logic [7:0] ch_buf;
    logic [7:0] ch_live;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [5:0] pcnt;
    logic phase;
    logic first_pend;
    logic trig_pend;
    adc_cmp_pkg::conv_state_t state;
    logic [1:0] kind;
    logic [5:0] hcnt;
    logic sample_pulse;
    logic done_pulse;
  } state_t;

  state_t st;
  state_t next_st;

  // half period of the converter clock minus one, in system clocks
  function automatic logic [5:0] half_limit(input logic [2:0] sel);
    logic [6:0] half;
    half = (sel == 3'h0) ? 7'h01 : 7'(7'h01 << (sel - 3'h1));
    return 6'(half - 7'h01);
  endfunction

  function automatic logic [5:0] half_total(input logic [1:0] k);
    case (k)
      adc_cmp_pkg::K_FIRST: return adc_cmp_pkg::HALF_TOT_FIRST;
      adc_cmp_pkg::K_AUTO: return adc_cmp_pkg::HALF_TOT_AUTO;
      adc_cmp_pkg::K_FREE: return adc_cmp_pkg::HALF_TOT_FREE;
      default: return adc_cmp_pkg::HALF_TOT_NORMAL;
    endcase
  endfunction

  function automatic logic [5:0] half_sample(input logic [1:0] k);
    case (k)
      adc_cmp_pkg::K_FIRST: return adc_cmp_pkg::HALF_SH_FIRST;
      adc_cmp_pkg::K_AUTO: return adc_cmp_pkg::HALF_SH_AUTO;
      adc_cmp_pkg::K_FREE: return adc_cmp_pkg::HALF_SH_FREE;
      default: return adc_cmp_pkg::HALF_SH_NORMAL;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == adc_cmp_pkg::OFS_CTRL_A || a == adc_cmp_pkg::OFS_CTRL_B ||
      a == adc_cmp_pkg::OFS_CMP_CS || a == adc_cmp_pkg::OFS_CH_SEL;
  endfunction

  // ****************************************
  // derived terms
  // ****************************************
  logic enable;
  logic half_tick;
  logic rise;
  logic free_mode;
  logic cmp_event;
  logic [5:0] hnext;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;

  // free running when auto-trigger on and trigger source zero
  assign enable = st.ctrl_a[adc_cmp_pkg::A_ENABLE];
  assign free_mode = st.ctrl_a[adc_cmp_pkg::A_AUTO] && st.ctrl_b[2:0] == 3'h0;
  assign half_tick = enable && st.pcnt == half_limit(st.ctrl_a[2:0]);
  assign rise = half_tick && !st.phase;
  assign hnext = 6'(st.hcnt + 6'h01);
  // event decode on the second sync stage, never on the first
  always_comb
  begin
    case (st.cmp_cs[1:0])
      adc_cmp_pkg::M_TOGGLE: cmp_event = st.sync2 != st.sync3;
      adc_cmp_pkg::M_FALL: cmp_event = !st.sync2 && st.sync3;
      adc_cmp_pkg::M_RISE: cmp_event = st.sync2 && !st.sync3;
      default: cmp_event = 1'b0;
    endcase
  end

  // bus handshakes, one write and one read in flight
  assign o_axi.awready = !st.aw_have && !st.bvalid;
  assign o_axi.wready = !st.w_have && !st.bvalid;
  assign o_axi.arready = !st.rvalid;
  assign o_axi.bvalid = st.bvalid;
  assign o_axi.bresp = st.bresp;
  assign o_axi.rvalid = st.rvalid;
  assign o_axi.rdata = {24'h000000, st.rdata};
  assign o_axi.rresp = st.rresp;
  assign aw_take = i_axi.awvalid && o_axi.awready;
  assign w_take = i_axi.wvalid && o_axi.wready;
  assign ar_take = i_axi.arvalid && o_axi.arready;
  assign do_write = st.aw_have && st.w_have && !st.bvalid;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.sample_pulse = 1'b0;
    next_st.done_pulse = 1'b0;
    // write channels taken in either order
    if (aw_take)
    begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = i_axi.awaddr;
    end
    if (w_take)
    begin
      next_st.w_have = 1'b1;
      next_st.w_data = i_axi.wdata[7:0];
      next_st.w_lane = i_axi.wstrb[0];
    end
    if (st.bvalid && i_axi.bready)
      next_st.bvalid = 1'b0;
    if (do_write)
    begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.aw_addr) ? adc_cmp_pkg::RESP_OKAY :
        adc_cmp_pkg::RESP_SLVERR;
      if (!st.w_lane)
        next_st.bresp = next_st.bresp;
      else if (st.aw_addr == adc_cmp_pkg::OFS_CTRL_A)
      begin
        // start is set-only, done flag is write-one-to-clear
        next_st.ctrl_a[7] = st.w_data[7];
        next_st.ctrl_a[6] = st.ctrl_a[6] | st.w_data[6];
        next_st.ctrl_a[5] = st.w_data[5];
        next_st.ctrl_a[4] = st.ctrl_a[4] & ~st.w_data[4];
        next_st.ctrl_a[3:0] = st.w_data[3:0];
      end
      else if (st.aw_addr == adc_cmp_pkg::OFS_CTRL_B)
        next_st.ctrl_b = st.w_data;
      else if (st.aw_addr == adc_cmp_pkg::OFS_CMP_CS)
      begin
        next_st.cmp_cs[7:6] = st.w_data[7:6];
        next_st.cmp_cs[4] = st.cmp_cs[4] & ~st.w_data[4];
        next_st.cmp_cs[3:0] = st.w_data[3:0];
      end
      else if (st.aw_addr == adc_cmp_pkg::OFS_CH_SEL)
        next_st.ch_buf = st.w_data;
    end
    // read path, answer one cycle after the address is taken
    if (st.rvalid && i_axi.rready)
      next_st.rvalid = 1'b0;
    if (ar_take)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = is_mapped(i_axi.araddr) ? adc_cmp_pkg::RESP_OKAY :
        adc_cmp_pkg::RESP_SLVERR;
      if (i_axi.araddr == adc_cmp_pkg::OFS_CTRL_A)
        next_st.rdata = st.ctrl_a;
      else if (i_axi.araddr == adc_cmp_pkg::OFS_CTRL_B)
        next_st.rdata = st.ctrl_b;
      else if (i_axi.araddr == adc_cmp_pkg::OFS_CMP_CS)
        next_st.rdata = {st.cmp_cs[7:6], st.sync2, st.cmp_cs[4:0]};
      else if (i_axi.araddr == adc_cmp_pkg::OFS_CH_SEL)
        next_st.rdata = st.ch_buf;
      else
        next_st.rdata = adc_cmp_pkg::RST_REG;
    end
    // comparator output synchroniser and edge history
    next_st.sync1 = i_comp_raw;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    // event flag: vector ack clears, a new event wins
    if (i_comp_irq_ack)
      next_st.cmp_cs[adc_cmp_pkg::C_FLAG] = 1'b0;
    if (cmp_event)
      next_st.cmp_cs[adc_cmp_pkg::C_FLAG] = 1'b1;
    // converter prescaler runs only while enabled
    if (!enable)
    begin
      next_st.pcnt = 6'h00;
      next_st.phase = 1'b0;
      next_st.first_pend = 1'b1;
      next_st.trig_pend = 1'b0;
      next_st.ctrl_a[adc_cmp_pkg::A_START] = 1'b0;
      next_st.state = adc_cmp_pkg::S_IDLE;
      next_st.hcnt = 6'h00;
    end
    else if (half_tick)
    begin
      next_st.pcnt = 6'h00;
      next_st.phase = !st.phase;
    end
    else
      next_st.pcnt = 6'(st.pcnt + 6'h01);
    // external trigger caught for the next converter edge
    if (enable && i_trigger && st.ctrl_a[adc_cmp_pkg::A_AUTO] && !free_mode)
      next_st.trig_pend = 1'b1;
    // channel select tracks buffer except while locked
    if (st.state == adc_cmp_pkg::S_IDLE ||
        st.hcnt >= 6'(half_total(st.kind) - 6'h02))
      next_st.ch_live = st.ch_buf;
    if (enable)
    begin
      case (st.state)
        adc_cmp_pkg::S_IDLE:
        begin
          // start only at a converter clock rising edge
          if (rise && (st.ctrl_a[adc_cmp_pkg::A_START] || st.trig_pend))
          begin
            next_st.state = adc_cmp_pkg::S_BUSY;
            next_st.hcnt = 6'h00;
            next_st.first_pend = 1'b0;
            next_st.trig_pend = 1'b0;
            next_st.ctrl_a[adc_cmp_pkg::A_START] = 1'b1;
            if (st.first_pend)
              next_st.kind = adc_cmp_pkg::K_FIRST;
            else if (st.trig_pend)
              next_st.kind = adc_cmp_pkg::K_AUTO;
            else
              next_st.kind = adc_cmp_pkg::K_NORMAL;
          end
        end
        adc_cmp_pkg::S_BUSY:
        begin
          if (half_tick)
          begin
            next_st.hcnt = hnext;
            if (hnext == half_sample(st.kind))
              next_st.sample_pulse = 1'b1;
            if (hnext == half_total(st.kind))
            begin
              next_st.done_pulse = 1'b1;
              next_st.ctrl_a[adc_cmp_pkg::A_DONE] = 1'b1;
              next_st.hcnt = 6'h00;
              if (free_mode && st.ctrl_a[adc_cmp_pkg::A_START])
                next_st.kind = adc_cmp_pkg::K_FREE;
              else
              begin
                next_st.state = adc_cmp_pkg::S_IDLE;
                next_st.ctrl_a[adc_cmp_pkg::A_START] = 1'b0;
              end
            end
          end
        end
        default: next_st.state = adc_cmp_pkg::S_IDLE;
      endcase
    end
    // done flag: vector ack clears unless set in the same cycle
    if (i_conv_irq_ack && !next_st.done_pulse)
      next_st.ctrl_a[adc_cmp_pkg::A_DONE] = 1'b0;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end

  // analog routing and pin-facing outputs
  assign o_comp_neg_from_mux = st.ctrl_b[adc_cmp_pkg::B_MUX_EN] && !enable;
  assign o_comp_pos_bandgap = st.cmp_cs[adc_cmp_pkg::C_BANDGAP];
  assign o_comp_power_down = st.cmp_cs[adc_cmp_pkg::C_DISABLE];
  assign o_capture_input = st.cmp_cs[adc_cmp_pkg::C_ROUTE] && st.sync2;
  assign o_comp_irq = st.cmp_cs[adc_cmp_pkg::C_FLAG] &&
    st.cmp_cs[adc_cmp_pkg::C_IRQ_EN] && i_global_irq_enable;
  assign o_converter_clock = st.phase;
  assign o_sample_hold = st.sample_pulse;
  assign o_conversion_done = st.done_pulse;
  assign o_first_conversion = st.state == adc_cmp_pkg::S_BUSY &&
    st.kind == adc_cmp_pkg::K_FIRST;
  assign o_channel_select = st.ch_live;
  assign o_conv_irq = st.ctrl_a[adc_cmp_pkg::A_DONE] &&
    st.ctrl_a[adc_cmp_pkg::A_IRQ_EN] && i_global_irq_enable;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  neg_input_route_a: assert property (st.ctrl_b[6] && !enable |-> o_comp_neg_from_mux)
    else $error("mux not routed to comparator");
  sync_delay_two_a: assert property (i_ce ##1 i_ce ##1 1'b1 |->
    st.sync2 == $past(i_comp_raw, 2))
    else $error("comparator status not two cycles late");
  event_sets_flag_a: assert property (cmp_event && i_ce |=> st.cmp_cs[4])
    else $error("event did not set flag");
  irq_gating_a: assert property (o_comp_irq |-> st.cmp_cs[3] && st.cmp_cs[4])
    else $error("comparator irq without flag and enable");
  presc_held_a: assert property (!enable && i_ce |=> st.pcnt == 6'h00 && !st.phase)
    else $error("prescaler ran while disabled");
  start_on_rise_a: assert property (st.state == adc_cmp_pkg::S_IDLE && i_ce &&
    $rose(st.state[0]) == 1'b0 && !rise |=> st.state == adc_cmp_pkg::S_IDLE)
    else $error("conversion began off a converter edge");
  done_length_a: assert property (st.state == adc_cmp_pkg::S_BUSY && half_tick && i_ce &&
    st.hcnt == 6'(half_total(st.kind) - 6'h01) |=> o_conversion_done && st.ctrl_a[4])
    else $error("conversion did not end at its length");
  first_total_a: assert property (o_conversion_done && $past(st.kind) ==
    adc_cmp_pkg::K_FIRST |-> $past(hnext) == 6'h32)
    else $error("first conversion not 25 cycles");
  sample_point_a: assert property (o_sample_hold |->
    $past(hnext) == half_sample($past(st.kind)))
    else $error("sample not at its half cycle");
  channel_lock_a: assert property (st.state == adc_cmp_pkg::S_BUSY &&
    st.hcnt < 6'h10 |=> $stable(o_channel_select))
    else $error("channel select changed while locked");
  first_cov: cover property (o_conversion_done && $past(st.kind) == adc_cmp_pkg::K_FIRST);
  free_cov: cover property (o_conversion_done && st.kind == adc_cmp_pkg::K_FREE);
  event_cov: cover property (cmp_event && st.cmp_cs[1:0] == adc_cmp_pkg::M_RISE);
endmodule // adc_cmp_ctrl

// ===== verilog/adc_cmp_pkg.sv
// package for the converter timing and comparator control block
// assumes a single 100 MHz clock and an AXI4-Lite master with 8-bit byte addresses
package adc_cmp_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CMP_CS = 8'h08;
  localparam logic [7:0] OFS_CH_SEL = 8'h0c;
  // converter_control_a fields
  localparam int A_ENABLE = 7;
  localparam int A_START = 6;
  localparam int A_AUTO = 5;
  localparam int A_DONE = 4;
  localparam int A_IRQ_EN = 3;
  // converter_control_b fields
  localparam int B_MUX_EN = 6;
  // comparator_control_status fields
  localparam int C_DISABLE = 7;
  localparam int C_BANDGAP = 6;
  localparam int C_OUT = 5;
  localparam int C_FLAG = 4;
  localparam int C_IRQ_EN = 3;
  localparam int C_ROUTE = 2;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // conversion timing, in half converter cycles
  // ****************************************
  localparam logic [5:0] HALF_TOT_NORMAL = 6'h1a; // 13 cycles
  localparam logic [5:0] HALF_TOT_FIRST = 6'h32; // 25 cycles
  localparam logic [5:0] HALF_TOT_AUTO = 6'h1b; // 13.5 cycles
  localparam logic [5:0] HALF_TOT_FREE = 6'h1c; // 14 cycles
  localparam logic [5:0] HALF_SH_NORMAL = 6'h03; // 1.5 cycles
  localparam logic [5:0] HALF_SH_FIRST = 6'h1b; // 13.5 cycles
  localparam logic [5:0] HALF_SH_AUTO = 6'h04; // 2 cycles
  localparam logic [5:0] HALF_SH_FREE = 6'h05; // 2.5 cycles
  // conversion kinds
  localparam logic [1:0] K_NORMAL = 2'h0;
  localparam logic [1:0] K_FIRST = 2'h1;
  localparam logic [1:0] K_AUTO = 2'h2;
  localparam logic [1:0] K_FREE = 2'h3;
  // comparator event modes
  localparam logic [1:0] M_TOGGLE = 2'h0;
  localparam logic [1:0] M_FALL = 2'h2;
  localparam logic [1:0] M_RISE = 2'h3;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_BUSY = 2'b01} conv_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;
endpackage

// ===== verification/adc_cmp_analog.sv
// partner model: analog comparator core and auto-trigger source
// assumes the bench sets the wanted comparator level and trigger requests
module adc_cmp_analog
(
  // clock
  input wire logic i_mclk,
  // requests from the bench, power down from the block
  input wire logic i_level,
  input wire logic i_power_down,
  input wire logic i_fire,
  // towards the block
  output logic o_comp_raw,
  output logic o_trigger
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // analog core
  // ****************************************
  // one clock of settling; an unpowered core reads low, not its last level
  always_ff @(posedge i_mclk)
  begin
    o_comp_raw <= i_power_down ? 1'b0 : i_level;
    o_trigger <= i_fire;
  end
endmodule // adc_cmp_analog

// ===== verification/tb_top.sv
// self-checking bench for the converter timing and comparator control block
// assumes the analog partner model and a 100 MHz clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals and instances
  // ****************************************
  logic i_mclk, i_rst, lvl, fire, gie, cack;
  adc_cmp_pkg::axi_req_t req;
  adc_cmp_pkg::axi_rsp_t rsp;
  logic raw, trig, negm, bgap, pdn, capt, cirq, cclk, shold, done, first, virq;
  logic [7:0] chan;
  int n_fail = 0;
  int num_checks = 0;
  adc_cmp_analog i_adc_cmp_analog (.i_mclk(i_mclk), .i_level(lvl), .i_power_down(pdn),
    .i_fire(fire), .o_comp_raw(raw), .o_trigger(trig));
  adc_cmp_ctrl i_adc_cmp_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .i_axi(req),
    .o_axi(rsp), .i_comp_raw(raw), .i_comp_irq_ack(cack), .i_global_irq_enable(gie),
    .o_comp_neg_from_mux(negm), .o_comp_pos_bandgap(bgap), .o_comp_power_down(pdn),
    .o_capture_input(capt), .o_comp_irq(cirq), .i_trigger(trig), .i_conv_irq_ack(1'b0),
    .o_converter_clock(cclk), .o_sample_hold(shold), .o_conversion_done(done),
    .o_first_conversion(first), .o_channel_select(chan), .o_conv_irq(virq));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // every polled wait goes through here so a hang ends the run
  task automatic tick(inout int n);
    @(posedge i_mclk);
    n++;
    if (n > 400)
    begin
      n_fail++;
      $display("ERROR wait expected event seen timeout");
      end_sim();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
  endtask
  task automatic set_lvl(input logic v);
    @(posedge i_mclk);
    lvl <= v;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do
    begin
      tick(n);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("write response", rsp.bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge i_mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      tick(n);
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    d = rsp.rdata[7:0];
    chk("read response", rsp.rresp, er);
    chk("read upper bits", rsp.rdata[31:8], 32'h0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(i * 4), d, adc_cmp_pkg::RESP_OKAY);
      chk("reset value", d, adc_cmp_pkg::RST_REG);
    end
    rd(8'h10, d, adc_cmp_pkg::RESP_SLVERR);
    chk("unmapped read", d, 8'h00);
    wr(8'h10, 8'hff, adc_cmp_pkg::RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_route();
    logic [7:0] d;
    wr(adc_cmp_pkg::OFS_CTRL_B, 8'h47, adc_cmp_pkg::RESP_OKAY);
    rd(adc_cmp_pkg::OFS_CTRL_B, d, adc_cmp_pkg::RESP_OKAY);
    chk("ctrl_b readback", d, 8'h47);
    chk("mux to comparator", negm, 1'b1);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'h80, adc_cmp_pkg::RESP_OKAY);
    cyc(1);
    chk("mux with converter on", negm, 1'b0);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'h00, adc_cmp_pkg::RESP_OKAY);
    wr(adc_cmp_pkg::OFS_CTRL_B, 8'h00, adc_cmp_pkg::RESP_OKAY);
    cyc(1);
    chk("negative pin", negm, 1'b0);
    // irq enable stays clear while the disable bit moves
    wr(adc_cmp_pkg::OFS_CMP_CS, 8'h40, adc_cmp_pkg::RESP_OKAY);
    cyc(1);
    chk("bandgap select", {bgap, pdn}, 2'b10);
    wr(adc_cmp_pkg::OFS_CMP_CS, 8'h80, adc_cmp_pkg::RESP_OKAY);
    cyc(1);
    chk("power down", {bgap, pdn}, 2'b01);
    wr(adc_cmp_pkg::OFS_CMP_CS, 8'h00, adc_cmp_pkg::RESP_OKAY);
    $display("test route done");
  endtask
  task automatic t_event();
    int n;
    logic [7:0] d;
    logic [1:0] m;
    gie <= 1'b1;
    wr(adc_cmp_pkg::OFS_CMP_CS, 8'h0c, adc_cmp_pkg::RESP_OKAY);
    set_lvl(1'b1);
    n = 0;
    // bench plays the timer front end and polls the capture input
    do
      tick(n);
    while (capt !== 1'b1);
    chk("sync delay", n >= 3 && n <= 4, 1'b1);
    cyc(2);
    chk("toggle irq", cirq, 1'b1);
    @(posedge i_mclk);
    gie <= 1'b0;
    @(posedge i_mclk);
    chk("global gate", cirq, 1'b0);
    gie <= 1'b1;
    cack <= 1'b1;
    @(posedge i_mclk);
    cack <= 1'b0;
    @(posedge i_mclk);
    chk("vector clears flag", cirq, 1'b0);
    rd(adc_cmp_pkg::OFS_CMP_CS, d, adc_cmp_pkg::RESP_OKAY);
    chk("status after ack", d, 8'h2c);
    wr(adc_cmp_pkg::OFS_CMP_CS, 8'h10, adc_cmp_pkg::RESP_OKAY);
    cyc(1);
    chk("route off", capt, 1'b0);
    // every event mode code, both edges
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      set_lvl(1'b0);
      cyc(6);
      wr(adc_cmp_pkg::OFS_CMP_CS, 8'h18 | 8'(m), adc_cmp_pkg::RESP_OKAY);
      chk("write one clears", cirq, 1'b0);
      set_lvl(1'b1);
      cyc(6);
      chk("rise event", cirq, m == adc_cmp_pkg::M_TOGGLE || m == adc_cmp_pkg::M_RISE);
      wr(adc_cmp_pkg::OFS_CMP_CS, 8'h18 | 8'(m), adc_cmp_pkg::RESP_OKAY);
      set_lvl(1'b0);
      cyc(6);
      chk("fall event", cirq, m == adc_cmp_pkg::M_TOGGLE || m == adc_cmp_pkg::M_FALL);
    end
    wr(adc_cmp_pkg::OFS_CMP_CS, 8'h10, adc_cmp_pkg::RESP_OKAY);
    $display("test event done");
  endtask
  // times taken from the clock so a register write can sit mid-conversion
  task automatic conv(input int lo, input int hi, input logic fst, input logic [7:0] ch);
    int n;
    time t0;
    logic [7:0] old;
    n = 0;
    do
      tick(n);
    while (shold !== 1'b1);
    t0 = $time;
    old = chan;
    chk("start to sample", n >= lo && n <= hi, 1'b1);
    chk("first flag", first, fst);
    wr(adc_cmp_pkg::OFS_CH_SEL, ch, adc_cmp_pkg::RESP_OKAY);
    // give an unlocked select time to follow the new buffer value
    cyc(2);
    chk("channel locked", chan, old);
    n = 0;
    do
      tick(n);
    while (done !== 1'b1);
    chk("sample to done", 32'(($time - t0) / 10), 32'd23);
    cyc(2);
    chk("channel follows", chan, ch);
  endtask
  task automatic t_conv();
    int n;
    logic acc;
    time t0;
    // fast ratios keep the run short; real software picks a slower one
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'h82, adc_cmp_pkg::RESP_OKAY);
    n = 0;
    do
      tick(n);
    while (cclk !== 1'b1);
    do
      tick(n);
    while (cclk !== 1'b0);
    n = 0;
    do
      tick(n);
    while (cclk !== 1'b1);
    do
      tick(n);
    while (cclk !== 1'b0);
    chk("prescaler period", n, 4);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'h02, adc_cmp_pkg::RESP_OKAY);
    acc = 1'b0;
    repeat (12)
    begin
      @(posedge i_mclk);
      acc = acc | cclk;
    end
    chk("prescaler held", acc, 1'b0);
    wr(adc_cmp_pkg::OFS_CH_SEL, 8'h05, adc_cmp_pkg::RESP_OKAY);
    cyc(2);
    chk("channel idle", chan, 8'h05);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'h80, adc_cmp_pkg::RESP_OKAY);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'hc0, adc_cmp_pkg::RESP_OKAY);
    conv(24, 31, 1'b1, 8'h0a);
    chk("conversion irq masked", virq, 1'b0);
    // done flag cleared and conversion irq enabled with the start
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'hd8, adc_cmp_pkg::RESP_OKAY);
    conv(1, 7, 1'b0, 8'h03);
    chk("conversion irq", virq, 1'b1);
    wr(adc_cmp_pkg::OFS_CTRL_B, 8'h01, adc_cmp_pkg::RESP_OKAY);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'hb0, adc_cmp_pkg::RESP_OKAY);
    @(posedge i_mclk);
    fire <= 1'b1;
    @(posedge i_mclk);
    fire <= 1'b0;
    conv(1, 8, 1'b0, 8'h06);
    wr(adc_cmp_pkg::OFS_CTRL_B, 8'h00, adc_cmp_pkg::RESP_OKAY);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'hf0, adc_cmp_pkg::RESP_OKAY);
    n = 0;
    do
      tick(n);
    while (done !== 1'b1);
    t0 = $time;
    n = 0;
    do
      tick(n);
    while (done !== 1'b1);
    chk("free running period", 32'(($time - t0) / 10), 32'd28);
    wr(adc_cmp_pkg::OFS_CTRL_A, 8'h00, adc_cmp_pkg::RESP_OKAY);
    $display("test conv done");
  endtask
  // ****************************************
  // clock and main sequence
  // ****************************************
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial
  begin
    i_rst = 1'b1;
    req = '0;
    lvl = 1'b0;
    fire = 1'b0;
    gie = 1'b0;
    cack = 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_regs();
    t_route();
    t_event();
    t_conv();
    end_sim();
  end
endmodule // tb_top
